// *** rtl/reset_cause_capture.sv ***
`timescale 1ns/100ps

module reset_cause_capture (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       wdog_caused_reset,
  output logic [7:0]      cause_code,
  output logic            cause_valid
);

  sf_regs_pkg::cause_state_t cur_ff;
  sf_regs_pkg::cause_state_t nxt_cur;

  // ******************************
  // capture after release
  // ******************************
  // the level comes from the reset generator, so it is caught by a clock
  // edge after srst falls, never loaded by the reset itself
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.sync = {cur_ff.sync[1:0], wdog_caused_reset};
    if (!cur_ff.captured && (cur_ff.sync[1] == cur_ff.sync[2])) begin
      nxt_cur.captured = 1'b1;
      nxt_cur.cause    = cur_ff.sync[2] ? sf_regs_pkg::CAUSE_WDOG
                                        : sf_regs_pkg::CAUSE_PIN;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // chain keeps shifting through reset so it is settled at release;
      // a cleared chain would be caught as a pin reset on the first edge
      cur_ff <= '{sync: nxt_cur.sync, captured: 1'b0,
                  cause: sf_regs_pkg::CAUSE_PIN};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign cause_code  = cur_ff.cause;
  assign cause_valid = cur_ff.captured;

endmodule // reset_cause_capture

// *** rtl/sf_regs_pkg.sv ***
package sf_regs_pkg;

  // ******************************
  // bus geometry
  // ******************************
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BE_W   = DATA_W / 8;

  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [ADDR_W-1:0] OFS_ID_WORD   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_ID_EXT    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CAUSE     = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_GUARD     = 5'h18;

  // ******************************
  // identity word layout
  // ******************************
  localparam int VERSION_LSB   = 0;
  localparam int VERSION_W     = 5;
  localparam int VERSION_MAX   = 31;
  localparam int FIXED_LSB     = 5;
  localparam logic [2:0] FIXED_PATTERN = 3'h2;
  localparam int PNVM_LSB      = 8;
  localparam int DNVM_LSB      = 12;
  localparam int VRAM_LSB      = 16;
  localparam int FAMILY_LSB    = 20;
  localparam int PTYPE_LSB     = 28;
  localparam int MORE_ID_BIT   = 31;

  // program nonvolatile size codes
  localparam logic [3:0] PNVM_NONE = 4'h0;
  localparam logic [3:0] PNVM_32K  = 4'h3;
  localparam logic [3:0] PNVM_64K  = 4'h5;
  localparam logic [3:0] PNVM_128K = 4'h7;
  localparam logic [3:0] PNVM_256K = 4'h9;
  // data nonvolatile size codes
  localparam logic [3:0] DNVM_NONE = 4'h0;
  // volatile ram size codes
  localparam logic [3:0] VRAM_NONE = 4'h0;
  localparam logic [3:0] VRAM_1K   = 4'h1;
  localparam logic [3:0] VRAM_2K   = 4'h2;
  localparam logic [3:0] VRAM_4K   = 4'h4;
  localparam logic [3:0] VRAM_8K   = 4'h8;
  // program memory type codes
  localparam logic [2:0] PTYPE_M   = 3'h1;
  localparam logic [2:0] PTYPE_R   = 3'h4;

  // ******************************
  // reset cause and guard mode
  // ******************************
  localparam logic [7:0]  CAUSE_PIN    = 8'h6c;
  localparam logic [7:0]  CAUSE_WDOG   = 8'h53;
  localparam logic [15:0] UNLOCK_KEY   = 16'h27a8;
  localparam int          KEY_LSB      = 16;
  localparam int          GUARD_BIT    = 5;
  localparam logic        GUARD_RST    = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ******************************
  // types
  // ******************************
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0]   byteenable;
  } avmm_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_fsm_t;

  typedef struct packed {
    bus_fsm_t          fsm;
    logic              waitrequest;
    logic [DATA_W-1:0] readdata;
    logic              guard;
  } regs_state_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       captured;
    logic [7:0] cause;
  } cause_state_t;

  // ******************************
  // legality of identity fields
  // ******************************
  function automatic logic pnvm_legal(input logic [3:0] c);
    return c == PNVM_NONE || c == PNVM_32K || c == PNVM_64K ||
           c == PNVM_128K || c == PNVM_256K;
  endfunction

  function automatic logic vram_legal(input logic [3:0] c);
    return c == VRAM_NONE || c == VRAM_1K || c == VRAM_2K ||
           c == VRAM_4K || c == VRAM_8K;
  endfunction

  function automatic logic bcd_legal(input logic [7:0] c);
    return c[7:4] <= 4'h9 && c[3:0] <= 4'h9;
  endfunction

endpackage

// *** rtl/special_function_id_reset_regs.sv ***
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
// Overview of operation
// - bits 4:0 of the identity word hold the silicon version, 0 up to 31.
// - program nvm size codes 0,3,5,7,9 mean none,32K,64K,128K,256K bytes.
// - data nvm size only defines code 0, meaning none present.
// - volatile ram size codes 0,1,2,4,8 mean none,1K,2K,4K,8K bytes.
// - the family code byte is two bcd digits naming the product family.
// - program memory type is one of two defined codes, others reserved.
// - bit 31 reads 1 only when an extended identity exists.
// - the identity extension word at 0x04 is reserved and reads zero.
// - reset cause low byte reads 0x6c after pin reset, 0x53 after watchdog.
// - guard mode writes apply only with key 0x27a8 on top, key reads 0.
// - a guard mode write with a wrong key leaves the register unchanged.
// - guard mode bit 5 selects normal (0) or protect (1) interrupt mode.

module special_function_id_reset_regs #(
  parameter logic [4:0] VERSION     = 5'h00,
  parameter logic [3:0] PNVM_SIZE   = 4'h0,
  parameter logic [3:0] DNVM_SIZE   = 4'h0,
  parameter logic [3:0] VRAM_SIZE   = 4'h8,
  // arbitrary neutral family code, two bcd digits
  parameter logic [7:0] FAMILY_CODE = 8'h12,
  parameter logic [2:0] PTYPE       = 3'h1,
  parameter logic       MORE_ID     = 1'b0
) (
  input  wire logic                          clock,
  input  wire logic                          srst,
  input  wire sf_regs_pkg::avmm_req_t        avmm_req,
  output logic [sf_regs_pkg::DATA_W-1:0]     avmm_readdata,
  output logic                               avmm_waitrequest,
  input  wire logic                          wdog_caused_reset,
  output logic                               interrupt_guard_enable
);

  // ******************************
  // elaboration checks
  // ******************************
  generate
    if (VERSION > sf_regs_pkg::VERSION_MAX) begin : g_bad_version
      $error("version field above its maximum");
    end
    if (!sf_regs_pkg::pnvm_legal(PNVM_SIZE)) begin : g_bad_pnvm
      $error("program nvm size code is reserved");
    end
    if (DNVM_SIZE != sf_regs_pkg::DNVM_NONE) begin : g_bad_dnvm
      $error("data nvm size code is reserved");
    end
    if (!sf_regs_pkg::vram_legal(VRAM_SIZE)) begin : g_bad_vram
      $error("volatile ram size code is reserved");
    end
    if (!sf_regs_pkg::bcd_legal(FAMILY_CODE)) begin : g_bad_family
      $error("family code is not two bcd digits");
    end
    if (PTYPE != sf_regs_pkg::PTYPE_M &&
        PTYPE != sf_regs_pkg::PTYPE_R) begin : g_bad_ptype
      $error("program memory type code is reserved");
    end
  endgenerate

  // ******************************
  // identity word
  // ******************************
  localparam logic [sf_regs_pkg::DATA_W-1:0] ID_WORD =
    (32'(MORE_ID)     << sf_regs_pkg::MORE_ID_BIT)   |
    (32'(PTYPE)       << sf_regs_pkg::PTYPE_LSB)     |
    (32'(FAMILY_CODE) << sf_regs_pkg::FAMILY_LSB)    |
    (32'(VRAM_SIZE)   << sf_regs_pkg::VRAM_LSB)      |
    (32'(DNVM_SIZE)   << sf_regs_pkg::DNVM_LSB)      |
    (32'(PNVM_SIZE)   << sf_regs_pkg::PNVM_LSB)      |
    (32'(sf_regs_pkg::FIXED_PATTERN) << sf_regs_pkg::FIXED_LSB) |
    (32'(VERSION)     << sf_regs_pkg::VERSION_LSB);

  // ******************************
  // decode helpers
  // ******************************
  function automatic logic addr_hit(
    input logic [sf_regs_pkg::ADDR_W-1:0] addr,
    input logic [sf_regs_pkg::ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction

  // key sits in bytes 3:2, so both lanes must be written for it to count
  function automatic logic key_ok(
    input logic [sf_regs_pkg::DATA_W-1:0] wd,
    input logic [sf_regs_pkg::BE_W-1:0]   be
  );
    return (be[3:2] == 2'h3) &&
           (wd[31:sf_regs_pkg::KEY_LSB] == sf_regs_pkg::UNLOCK_KEY);
  endfunction

  // ******************************
  // reset cause
  // ******************************
  logic [7:0] cause_code;
  sf_regs_pkg::regs_state_t cur_ff;
  sf_regs_pkg::regs_state_t nxt_cur;

  reset_cause_capture u_cause (
    .clock             (clock),
    .srst              (srst),
    .wdog_caused_reset (wdog_caused_reset),
    .cause_code        (cause_code),
    .cause_valid       ()
  );

  // ******************************
  // read mux
  // ******************************
  logic [sf_regs_pkg::DATA_W-1:0] rd_value;

  always_comb begin
    rd_value = sf_regs_pkg::DATA_ZERO;
    if (addr_hit(avmm_req.address, sf_regs_pkg::OFS_ID_WORD)) begin
      rd_value = ID_WORD;
    end else if (addr_hit(avmm_req.address, sf_regs_pkg::OFS_ID_EXT)) begin
      rd_value = sf_regs_pkg::DATA_ZERO;
    end else if (addr_hit(avmm_req.address, sf_regs_pkg::OFS_CAUSE)) begin
      rd_value = {24'h00_0000, cause_code};
    end else if (addr_hit(avmm_req.address, sf_regs_pkg::OFS_GUARD)) begin
      // key field and spare bits always read zero
      rd_value[sf_regs_pkg::GUARD_BIT] = cur_ff.guard;
    end
  end

  // ******************************
  // bus slave and guard register
  // ******************************
  // one wait cycle per access: costs a cycle, but readdata and waitrequest
  // both come straight from flops
  always_comb begin
    nxt_cur = cur_ff;
    unique case (cur_ff.fsm)
      sf_regs_pkg::ST_IDLE: begin
        if (avmm_req.read || avmm_req.write) begin
          nxt_cur.fsm         = sf_regs_pkg::ST_ACK;
          nxt_cur.waitrequest = 1'b0;
          nxt_cur.readdata    = avmm_req.read ? rd_value
                                              : sf_regs_pkg::DATA_ZERO;
        end
      end
      sf_regs_pkg::ST_ACK: begin
        nxt_cur.fsm         = sf_regs_pkg::ST_IDLE;
        nxt_cur.waitrequest = 1'b1;
        nxt_cur.readdata    = sf_regs_pkg::DATA_ZERO;
        // write lands on the edge where waitrequest is seen low;
        // other offsets simply drop the write
        if (avmm_req.write &&
            addr_hit(avmm_req.address, sf_regs_pkg::OFS_GUARD) &&
            key_ok(avmm_req.writedata, avmm_req.byteenable) &&
            avmm_req.byteenable[0]) begin
          nxt_cur.guard = avmm_req.writedata[sf_regs_pkg::GUARD_BIT];
        end
      end
      // illegal code: fall back to idle rather than lock the bus
      default: begin
        nxt_cur.fsm         = sf_regs_pkg::ST_IDLE;
        nxt_cur.waitrequest = 1'b1;
        nxt_cur.readdata    = sf_regs_pkg::DATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur_ff <= '{fsm:         sf_regs_pkg::ST_IDLE,
                  waitrequest: 1'b1,
                  readdata:    sf_regs_pkg::DATA_ZERO,
                  guard:       sf_regs_pkg::GUARD_RST};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign avmm_readdata          = cur_ff.readdata;
  assign avmm_waitrequest       = cur_ff.waitrequest;
  assign interrupt_guard_enable = cur_ff.guard;

endmodule // special_function_id_reset_regs

// *** tb/special_function_id_reset_regs_assertions.sv ***
`timescale 1ns/100ps
module special_function_id_reset_regs_assertions #(
  parameter logic [31:0] ID_WORD = 32'h0128_0040
) (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire sf_regs_pkg::avmm_req_t avmm_req,
  input wire logic [31:0]            avmm_readdata,
  input wire logic                   avmm_waitrequest,
  input wire logic                   wdog_caused_reset,
  input wire logic                   interrupt_guard_enable
);
  // ****************
  // bus and register checks
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic rq;
  logic key_ok;
  assign rq = avmm_req.read | avmm_req.write;
  assign key_ok = avmm_req.write && avmm_req.address == sf_regs_pkg::OFS_GUARD
    && avmm_req.byteenable[3:2] == 2'b11 && avmm_req.byteenable[0]
    && avmm_req.writedata[31:16] == sf_regs_pkg::UNLOCK_KEY;
  sequence s_ack;
    !avmm_waitrequest;
  endsequence
  sequence s_rd(logic [4:0] a);
    s_ack ##0 avmm_req.read ##0 avmm_req.address == a;
  endsequence

  a_take_answer: assert property (rq && avmm_waitrequest |=> !avmm_waitrequest)
    else $error("no answer one cycle after request");
  a_ack_one_cycle: assert property (s_ack |=> avmm_waitrequest)
    else $error("answer stood longer than one cycle");
  a_idle_zero_data: assert property (avmm_waitrequest |-> avmm_readdata == 0)
    else $error("read data not zero while waiting");
  a_id_value: assert property (
    s_rd(sf_regs_pkg::OFS_ID_WORD) |-> avmm_readdata == ID_WORD)
    else $error("identity word wrong");
  a_extension_zero: assert property (
    s_rd(sf_regs_pkg::OFS_ID_EXT) |-> avmm_readdata == 0)
    else $error("extension word not zero");
  a_cause_code: assert property (
    s_rd(sf_regs_pkg::OFS_CAUSE) |-> avmm_readdata inside {32'h6c, 32'h53})
    else $error("reset cause code wrong");
  a_guard_read: assert property (s_rd(sf_regs_pkg::OFS_GUARD) |->
    avmm_readdata == {26'h0, interrupt_guard_enable, 5'h0})
    else $error("guard readback wrong");
  a_key_apply: assert property (s_ack ##0 key_ok |=>
    interrupt_guard_enable == $past(avmm_req.writedata[5]))
    else $error("keyed guard write not applied");
  a_guard_hold: assert property (!(!avmm_waitrequest && key_ok)
    |=> $stable(interrupt_guard_enable))
    else $error("guard changed without keyed write");
endmodule // special_function_id_reset_regs_assertions

// *** tb/special_function_id_reset_regs_bench.sv ***
`timescale 1ns/100ps
module special_function_id_reset_regs_bench;
  // ****************
  // stimulus and checks
  // ****************
  // odd field values so a swapped or shifted field cannot pass
  localparam logic [31:0] ID_EXP = {1'b1, sf_regs_pkg::PTYPE_R, 8'h37,
    sf_regs_pkg::VRAM_1K, 4'h0, sf_regs_pkg::PNVM_256K, 3'h2, 5'h1f};
  localparam logic [31:0] GDAT [5] = '{32'h27a8_ffff, 32'h27a9_0000,
    32'h27a8_0000, 32'h27a8_0000, 32'h0000_0020};
  localparam logic [3:0] GBE [5] = '{4'hf, 4'hf, 4'hc, 4'hf, 4'hf};
  localparam logic GEXP [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic                   clock;
  logic                   srst;
  logic                   wdog;
  logic                   guard;
  logic [31:0]            rdata;
  logic                   wreq;
  logic [31:0]            rd;
  sf_regs_pkg::avmm_req_t req;
  int                     n_errors;
  int                     n_compared;

  special_function_id_reset_regs #(.VERSION(5'h1f),
    .PNVM_SIZE(sf_regs_pkg::PNVM_256K), .VRAM_SIZE(sf_regs_pkg::VRAM_1K),
    .FAMILY_CODE(8'h37), .PTYPE(sf_regs_pkg::PTYPE_R), .MORE_ID(1'b1)
  ) uut (.clock(clock), .srst(srst), .avmm_req(req), .avmm_readdata(rdata),
    .avmm_waitrequest(wreq), .wdog_caused_reset(wdog),
    .interrupt_guard_enable(guard));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one edge idle first, so back-to-back calls never drive twice at once
  task automatic xfer(input logic w, input logic [4:0] a,
      input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
    do begin
      @(posedge clock);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rd = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (wreq !== 1'b0) begin
      n_errors++;
      wrap_up();
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  // cause is captured on the first edge after release, so wait before reading
  task automatic do_reset(input logic w);
    wdog <= w;
    srst <= 1'b1;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    req = '0;
    n_errors = 0;
    n_compared = 0;
    do_reset(1'b0);
    rchk(sf_regs_pkg::OFS_ID_WORD, ID_EXP);
    rchk(sf_regs_pkg::OFS_ID_EXT, 32'h0);
    rchk(sf_regs_pkg::OFS_CAUSE, 32'h6c);
    rchk(sf_regs_pkg::OFS_GUARD, 32'h0);
    rchk(5'h0c, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 5'(4 * i), 32'h27a8_ffff, 4'hf);
      rchk(5'(4 * i), i == 0 ? ID_EXP : (i == 2 ? 32'h6c : 32'h0));
    end
    check({31'h0, guard}, 32'h0);
    $display("test read-only writes done");
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, sf_regs_pkg::OFS_GUARD, GDAT[i], GBE[i]);
      @(negedge clock);
      check({31'h0, guard}, {31'h0, GEXP[i]});
      rchk(sf_regs_pkg::OFS_GUARD, {26'h0, GEXP[i], 5'h0});
    end
    $display("test guard key done");
    xfer(1'b1, sf_regs_pkg::OFS_GUARD, 32'h27a8_0020, 4'hf);
    @(posedge clock);
    check({31'h0, guard}, 32'h1);
    do_reset(1'b1);
    rchk(sf_regs_pkg::OFS_CAUSE, 32'h53);
    rchk(sf_regs_pkg::OFS_GUARD, 32'h0);
    $display("test watchdog reset done");
    wrap_up();
  end
endmodule // special_function_id_reset_regs_bench

bind special_function_id_reset_regs special_function_id_reset_regs_assertions
  #(.ID_WORD({MORE_ID, PTYPE, FAMILY_CODE, VRAM_SIZE, DNVM_SIZE, PNVM_SIZE,
  3'h2, VERSION})) chk (.clock(clock), .srst(srst), .avmm_req(avmm_req),
  .avmm_readdata(avmm_readdata), .avmm_waitrequest(avmm_waitrequest),
  .wdog_caused_reset(wdog_caused_reset),
  .interrupt_guard_enable(interrupt_guard_enable));
